// ---- core/bba_pkg.sv ----
// package for the byte and bit execution slice: opcodes, register map,
// flag layout and the state carriers shared by the design.
// assumes a 14-bit instruction word and an 8-bit data path.
package bba_pkg;

    // =========================================================
    // widths and sizes
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;

    // =========================================================
    // opcode fields
    localparam logic [5:0] OPC_ADD_ACC_FILE = 6'h07;
    localparam logic [5:0] OPC_AND_ACC_FILE = 6'h05;
    localparam logic [5:0] OPC_AND_IMM = 6'h39;
    localparam logic [4:0] OPC_ADD_IMM = 5'h1f;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE = 4'h7;
    localparam int DEST_POS = 7;

    // =========================================================
    // register map, byte addresses
    localparam logic [11:0] REG_ACC = 12'h000;
    localparam logic [11:0] REG_FLAGS = 12'h004;
    localparam logic [11:0] REG_CYCLES = 12'h008;
    localparam logic [11:0] REG_FILE_BASE = 12'h200;
    localparam logic [11:0] REG_FILE_LAST = 12'h3fc;

    // flags register layout
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF_CARRY = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SKIP = 3;

    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [31:0] CYCLES_RESET = 32'h0000_0000;

    // =========================================================
    // types
    typedef enum logic [2:0] {
        OP_NO_OPERATION = 3'h0,
        OP_ADD_IMMEDIATE_TO_ACC = 3'h1,
        OP_ADD_ACC_AND_FILE = 3'h2,
        OP_AND_IMMEDIATE_WITH_ACC = 3'h3,
        OP_AND_ACC_WITH_FILE = 3'h4,
        OP_FILE_BIT_CLEAR = 3'h5,
        OP_FILE_BIT_SET = 3'h6,
        OP_TEST_BIT_SKIP = 3'h7
    } bba_op_t;

    typedef enum logic [1:0] {
        SEQ_RUN = 2'b00,
        SEQ_DISCARD = 2'b01
    } bba_seq_t;

    typedef struct packed {
        logic carry;
        logic half_carry;
        logic zero;
    } bba_flags_t;

    typedef struct packed {
        logic [FILE_DEPTH-1:0][DATA_W-1:0] file;
        logic [DATA_W-1:0] acc;
        bba_flags_t flags;
        bba_seq_t seq;
        logic [31:0] cycles;
        logic [31:0] prdata;
        logic pslverr;
        logic squashed;
    } bba_state_t;

endpackage

// ---- core/bba_core.sv ----
// execution slice for add, and, bit clear/set and bit-test-skip.
// assumes the decoder hands one instruction word per valid cycle and
// that software reaches state over a zero-wait-state apb slave.
`timescale 1ns/10ps
`default_nettype none

module bba_core
    import bba_pkg::*;
#(
    parameter logic [FADDR_W-1:0] PORT_ADDR = 7'h05
)(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // instruction from decoder
    input wire logic INSTR_VALID_IN,
    input wire logic [INSTR_W-1:0] INSTR_IN,
    // port pins
    input wire logic [DATA_W-1:0] PORT_PINS_IN,
    output logic [DATA_W-1:0] PORT_LATCH_OUT,
    // state seen by the sequencer
    output logic [DATA_W-1:0] ACC_OUT,
    output logic [2:0] FLAGS_OUT,
    output logic SKIP_NEXT_OUT,
    output logic SQUASHED_OUT,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT
);

    // =========================================================
    // decode
    function automatic bba_op_t decode(input logic [INSTR_W-1:0] w);
        bba_op_t op;
        op = OP_NO_OPERATION;
        if (w[13:9] == OPC_ADD_IMM)
            op = OP_ADD_IMMEDIATE_TO_ACC;
        else if (w[13:8] == OPC_AND_IMM)
            op = OP_AND_IMMEDIATE_WITH_ACC;
        else if (w[13:8] == OPC_ADD_ACC_FILE)
            op = OP_ADD_ACC_AND_FILE;
        else if (w[13:8] == OPC_AND_ACC_FILE)
            op = OP_AND_ACC_WITH_FILE;
        else if (w[13:10] == OPC_BIT_CLEAR)
            op = OP_FILE_BIT_CLEAR;
        else if (w[13:10] == OPC_BIT_SET)
            op = OP_FILE_BIT_SET;
        else if (w[13:11] == OPC_SKIP_ZERO[3:1])
            op = OP_TEST_BIT_SKIP;
        return op;
    endfunction

    function automatic logic reg_map_hit(input logic [11:0] a);
        return (a == REG_ACC) || (a == REG_FLAGS) || (a == REG_CYCLES) ||
            (a >= REG_FILE_BASE && a <= REG_FILE_LAST && a[1:0] == 2'b00);
    endfunction

    // =========================================================
    // state
    bba_state_t state;
    bba_state_t next_state;

    bba_op_t op;
    logic [FADDR_W-1:0] faddr;
    logic [2:0] bsel;
    logic dest_file;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] operand;
    logic [DATA_W:0] sum;
    logic [4:0] low_sum;
    logic [DATA_W-1:0] result;
    logic execute;
    logic skip_hit;
    logic apb_setup;
    logic apb_write;
    logic [FADDR_W-1:0] apb_faddr;

    assign op = decode(INSTR_IN);
    assign faddr = INSTR_IN[FADDR_W-1:0];
    assign bsel = INSTR_IN[9:7];
    assign dest_file = INSTR_IN[DEST_POS];
    assign imm = INSTR_IN[DATA_W-1:0];
    assign execute = INSTR_VALID_IN && (state.seq == SEQ_RUN);
    assign apb_setup = PSEL_IN && !PENABLE_IN;
    assign apb_write = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign apb_faddr = PADDR_IN[8:2];

    // port reads see the pins, not the latch
    assign fval = (faddr == PORT_ADDR) ? PORT_PINS_IN
        : state.file[faddr];
    assign operand = (op == OP_ADD_IMMEDIATE_TO_ACC ||
        op == OP_AND_IMMEDIATE_WITH_ACC) ? imm : fval;
    assign sum = {1'b0, state.acc} + {1'b0, operand};
    assign low_sum = {1'b0, state.acc[3:0]} + {1'b0, operand[3:0]};
    // skip-when-one has opcode bit 10 set
    assign skip_hit = (fval[bsel] == INSTR_IN[10]);

    // =========================================================
    // next state
    always_comb
    begin
        next_state = state;
        result = 8'h00;
        next_state.squashed = 1'b0;
        // apb writes land first so an instruction can override them
        if (apb_write)
        begin
            if (PADDR_IN == REG_ACC)
                next_state.acc = PWDATA_IN[DATA_W-1:0];
            else if (PADDR_IN == REG_FLAGS)
            begin
                next_state.flags.carry = PWDATA_IN[FLAG_CARRY];
                next_state.flags.half_carry = PWDATA_IN[FLAG_HALF_CARRY];
                next_state.flags.zero = PWDATA_IN[FLAG_ZERO];
            end
            else if (reg_map_hit(PADDR_IN) && PADDR_IN >= REG_FILE_BASE)
                next_state.file[apb_faddr] = PWDATA_IN[DATA_W-1:0];
        end
        if (INSTR_VALID_IN)
            next_state.cycles = state.cycles + 32'h0000_0001;
        if (INSTR_VALID_IN && state.seq == SEQ_DISCARD)
        begin
            // discarded slot runs as a no-operation
            next_state.seq = SEQ_RUN;
            next_state.squashed = 1'b1;
        end
        else if (execute)
        begin
            case (op)
                OP_ADD_IMMEDIATE_TO_ACC, OP_ADD_ACC_AND_FILE:
                begin
                    result = sum[DATA_W-1:0];
                    next_state.flags.carry = sum[DATA_W];
                    next_state.flags.half_carry = low_sum[4];
                    next_state.flags.zero = (result == 8'h00);
                    if (op == OP_ADD_ACC_AND_FILE && dest_file)
                        next_state.file[faddr] = result;
                    else
                        next_state.acc = result;
                end
                OP_AND_IMMEDIATE_WITH_ACC, OP_AND_ACC_WITH_FILE:
                begin
                    result = state.acc & operand;
                    next_state.flags.zero = (result == 8'h00);
                    if (op == OP_AND_ACC_WITH_FILE && dest_file)
                        next_state.file[faddr] = result;
                    else
                        next_state.acc = result;
                end
                OP_FILE_BIT_CLEAR:
                begin
                    result = fval;
                    result[bsel] = 1'b0;
                    next_state.file[faddr] = result;
                end
                OP_FILE_BIT_SET:
                begin
                    result = fval;
                    result[bsel] = 1'b1;
                    next_state.file[faddr] = result;
                end
                OP_TEST_BIT_SKIP:
                begin
                    if (skip_hit)
                        next_state.seq = SEQ_DISCARD;
                end
                default:
                begin
                    result = 8'h00;
                end
            endcase
        end
        // apb read data and error sampled in the setup cycle
        if (apb_setup)
        begin
            next_state.pslverr = !reg_map_hit(PADDR_IN);
            if (PADDR_IN == REG_ACC)
                next_state.prdata = {24'h000000, state.acc};
            else if (PADDR_IN == REG_FLAGS)
                next_state.prdata = {28'h0000000,
                    state.seq == SEQ_DISCARD, state.flags.zero,
                    state.flags.half_carry, state.flags.carry};
            else if (PADDR_IN == REG_CYCLES)
                next_state.prdata = state.cycles;
            else if (reg_map_hit(PADDR_IN))
                next_state.prdata = {24'h000000,
                    (apb_faddr == PORT_ADDR) ? PORT_PINS_IN
                    : state.file[apb_faddr]};
            else
                next_state.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state.file <= '0;
            state.acc <= ACC_RESET;
            state.flags <= '0;
            state.seq <= SEQ_RUN;
            state.cycles <= CYCLES_RESET;
            state.prdata <= 32'h0000_0000;
            state.pslverr <= 1'b0;
            state.squashed <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // =========================================================
    // outputs
    assign PORT_LATCH_OUT = state.file[PORT_ADDR];
    assign ACC_OUT = state.acc;
    assign FLAGS_OUT = {state.flags.zero, state.flags.half_carry,
        state.flags.carry};
    assign SKIP_NEXT_OUT = (state.seq == SEQ_DISCARD);
    assign SQUASHED_OUT = state.squashed;
    assign PRDATA_OUT = state.prdata;
    assign PREADY_OUT = PSEL_IN && PENABLE_IN;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && state.pslverr;

    // =========================================================
    // checks
    logic live_add_imm;
    logic live_and_imm;
    logic live_file_op;
    assign live_add_imm = execute && op == OP_ADD_IMMEDIATE_TO_ACC;
    assign live_and_imm = execute && op == OP_AND_IMMEDIATE_WITH_ACC;
    assign live_file_op = execute && faddr != PORT_ADDR;

    AST_ADD_IMM: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        live_add_imm |=> ACC_OUT == $past(state.acc) + $past(imm))
        else $error("add immediate result wrong");
    AST_ADD_FILE_DEST: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        live_file_op && op == OP_ADD_ACC_AND_FILE && dest_file &&
        !apb_write |=>
        state.file[$past(faddr)] == $past(sum[7:0]) &&
        ACC_OUT == $past(state.acc))
        else $error("add file to file wrong");
    AST_AND_IMM_FLAGS: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        live_and_imm && !apb_write |=> $stable(state.flags.carry) &&
        $stable(state.flags.half_carry) &&
        (ACC_OUT == ($past(state.acc) & $past(imm))))
        else $error("and immediate changed wrong bits");
    AST_AND_FILE_ACC: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        execute && op == OP_AND_ACC_WITH_FILE && !dest_file |=>
        ACC_OUT == ($past(state.acc) & $past(fval)))
        else $error("and file to acc wrong");
    AST_BIT_CLEAR: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        live_file_op && op == OP_FILE_BIT_CLEAR |=>
        state.file[$past(faddr)][$past(bsel)] == 1'b0)
        else $error("bit clear left bit set");
    AST_BIT_SET_FLAGS: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        live_file_op && op == OP_FILE_BIT_SET && !apb_write |=>
        state.file[$past(faddr)][$past(bsel)] == 1'b1 &&
        $stable(FLAGS_OUT))
        else $error("bit set wrong");
    AST_SKIP_ONE: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        execute && op == OP_TEST_BIT_SKIP && INSTR_IN[10] |=>
        SKIP_NEXT_OUT == $past(fval[bsel]))
        else $error("skip when one decision wrong");
    AST_SKIP_ZERO: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        execute && op == OP_TEST_BIT_SKIP && !INSTR_IN[10] && !fval[bsel]
        ##1 INSTR_VALID_IN && !apb_write |=>
        SQUASHED_OUT && !SKIP_NEXT_OUT && $stable(ACC_OUT))
        else $error("skip when zero did not discard");
    AST_PORT_OPERAND: assert property (@(posedge CLK_IN)
        disable iff (RST_IN)
        execute && op == OP_FILE_BIT_SET && faddr == PORT_ADDR |=>
        PORT_LATCH_OUT == ($past(PORT_PINS_IN) |
        (8'h01 << $past(bsel))))
        else $error("port modify used latch");
    AST_ONE_CYCLE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        execute && op != OP_TEST_BIT_SKIP |=> !SKIP_NEXT_OUT)
        else $error("non-skip took extra cycle");
    AST_ZERO_FLAG: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        live_add_imm && !apb_write |=> FLAGS_OUT[2] == (ACC_OUT == 8'h00))
        else $error("zero flag mismatch");

endmodule
`default_nettype wire

// ---- verification/bba_seq_model.sv ----
// partner model: decoder and sequencer handing one slot per cycle.
// assumes the bench fills slot_q and sets pins while the core idles.
`timescale 1ns/10ps
`default_nettype none
module bba_seq_model
    import bba_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // slot and pins
    output logic INSTR_VALID_OUT,
    output logic [INSTR_W-1:0] INSTR_OUT,
    output logic [DATA_W-1:0] PORT_PINS_OUT
);
    logic [INSTR_W:0] slot_q[$];
    logic [DATA_W-1:0] pins = 8'h00;
    assign PORT_PINS_OUT = pins;
    always @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            INSTR_VALID_OUT <= 1'h0;
            INSTR_OUT <= 14'h0000;
        end
        else if (slot_q.size() > 0)
            {INSTR_VALID_OUT, INSTR_OUT} <= slot_q.pop_front();
        else
        begin
            INSTR_VALID_OUT <= 1'h0;
            // idle word toggles, no stale value
            INSTR_OUT <= ~INSTR_OUT;
        end
    end
endmodule
`default_nettype wire

// ---- verification/test_byte_bit_alu_skip_exec.sv ----
// bench: random instruction streams against an integer model.
// assumes bba_core with a zero-wait apb slave and the slot partner.
`timescale 1ns/10ps
`default_nettype none
module test_byte_bit_alu_skip_exec
    import bba_pkg::*;
;
    localparam logic [6:0] PORT_F = 7'h05;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic valid, skipn, sq, pready, pslverr, err;
    logic [13:0] instr;
    logic [7:0] pins, latch, acc;
    logic [2:0] flags;
    logic [31:0] prdata, rd;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'hbc7a;
    int m_acc, m_c, m_dc, m_z, m_skip, m_sq, m_cyc, m_pins, sq_seen;
    int mf[128];
    int exp_q[$];
    logic vd_d = 1'h0;
    logic [31:0] got_s;
    always #4 clk = ~clk;
    bba_core #(.PORT_ADDR(PORT_F)) dut_u (.CLK_IN(clk), .RST_IN(rst),
        .INSTR_VALID_IN(valid), .INSTR_IN(instr), .PORT_PINS_IN(pins),
        .PORT_LATCH_OUT(latch), .ACC_OUT(acc), .FLAGS_OUT(flags),
        .SKIP_NEXT_OUT(skipn), .SQUASHED_OUT(sq), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr));
    bba_seq_model seq_u (.CLK_IN(clk), .RST_IN(rst),
        .INSTR_VALID_OUT(valid), .INSTR_OUT(instr), .PORT_PINS_OUT(pins));
    always @(posedge clk)
        if (sq === 1'h1) sq_seen++;
    // per-slot compare: state one edge after each executed slot
    always @(posedge clk)
    begin
        if (vd_d)
        begin
            got_s = {19'h0, sq, skipn, flags, acc};
            if (exp_q.size() == 0)
                error_cnt++;
            else
                chk_rd(got_s, exp_q.pop_front());
        end
        vd_d <= (valid === 1'h1) && !rst;
    end
    // =========================================================
    // checks and bus
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_out(input logic [7:0] g, input logic [7:0] e);
        chk_rd({24'h0, g}, {24'h0, e});
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk_rd(rd, e);
    endtask
    // =========================================================
    // model
    task automatic mdl_exec(input logic [13:0] w);
        int f, b, fv, r, d, wb;
        f = w[6:0];
        b = w[9:7];
        d = w[7];
        wb = 0;
        fv = (f == PORT_F) ? m_pins : mf[f];
        if (m_skip) begin m_skip = 0; m_sq++; return; end
        if (w[13:12] == 2'h3) begin fv = w[7:0]; d = 0; end
        if (w[13:8] == OPC_ADD_ACC_FILE || w[13:9] == OPC_ADD_IMM)
        begin
            r = m_acc + fv;
            m_c = r >> 8;
            m_dc = ((m_acc & 15) + (fv & 15)) >> 4;
            wb = 1;
        end
        else if (w[13:8] == OPC_AND_ACC_FILE || w[13:8] == OPC_AND_IMM)
        begin
            r = m_acc & fv;
            wb = 1;
        end
        else if (w[13:10] == OPC_BIT_CLEAR) mf[f] = fv & ~(1 << b);
        else if (w[13:10] == OPC_BIT_SET) mf[f] = fv | (1 << b);
        else if (w[13:11] == 3'h3) m_skip = ((fv >> b) & 1) == w[10];
        if (wb) m_z = ((r & 255) == 0);
        if (wb && d) mf[f] = r & 255;
        if (wb && !d) m_acc = r & 255;
    endtask
    task automatic push(input logic v, input logic [13:0] w);
        int s0;
        s0 = m_sq;
        seq_u.slot_q.push_back({v, w});
        if (v)
        begin
            m_cyc++;
            mdl_exec(w);
            exp_q.push_back(m_acc | (m_c << 8) | (m_dc << 9) | (m_z << 10) |
                (m_skip << 11) | ((m_sq - s0) << 12));
        end
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (seq_u.slot_q.size() > 0 && n < 2000) begin @(posedge clk); n++; end
        if (n >= 2000) error_cnt++;
        repeat (3) @(posedge clk);
    endtask
    task automatic final_chk();
        chk_out(acc, m_acc[7:0]);
        chk_out({5'h0, flags}, {5'h0, m_z[0], m_dc[0], m_c[0]});
        chk_out({7'h0, skipn}, {7'h0, m_skip[0]});
        chk_out(latch, mf[PORT_F][7:0]);
        chk_rd(sq_seen, m_sq);
        rdchk(REG_CYCLES, m_cyc);
        rdchk(REG_FLAGS, m_c | (m_dc << 1) | (m_z << 2) |
            (m_skip << 3));
        for (int f = 0; f < 128; f++)
            rdchk(REG_FILE_BASE + 12'(4 * f), (f == PORT_F) ? m_pins : mf[f]);
    endtask
    task automatic batch(input int n, input logic [7:0] pv);
        logic [31:0] r;
        logic [13:0] w;
        logic [6:0] f;
        @(posedge clk);
        seq_u.pins <= pv;
        m_pins = pv;
        for (int i = 0; i < n; i++)
        begin
            r = $random(seed);
            f = (r[9:8] == 2'h0) ? PORT_F : r[6:0];
            case (r[24:22])
                3'h0: w = {OPC_ADD_ACC_FILE, r[21], f};
                3'h1: w = {OPC_AND_ACC_FILE, r[21], f};
                3'h2: w = {OPC_AND_IMM, r[17:10]};
                3'h3: w = {OPC_ADD_IMM, 1'h0, r[17:10]};
                3'h4: w = {OPC_BIT_CLEAR, r[20:18], f};
                3'h5: w = {OPC_BIT_SET, r[20:18], f};
                3'h6: w = {OPC_SKIP_ZERO, r[20:18], f};
                default: w = {OPC_SKIP_ONE, r[20:18], f};
            endcase
            push(r[31:29] != 3'h0, w);
        end
        drain();
    endtask
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // =========================================================
    // sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        rdchk(REG_ACC, 32'h0);
        rdchk(REG_FLAGS, 32'h0);
        rdchk(REG_CYCLES, 32'h0);
        apb(1'h1, 12'h00c, 32'h5a);
        chk_rd({31'h0, err}, 32'h1);
        apb(1'h0, 12'h100, 32'h0);
        chk_rd({rd[30:0], err}, 32'h1);
        for (int f = 0; f < 128; f++)
        begin
            mf[f] = $random(seed) & 255;
            apb(1'h1, REG_FILE_BASE + 12'(4 * f), mf[f]);
        end
        apb(1'h1, REG_ACC, 32'h0f);
        m_acc = 15;
        // flag write lands, pending-skip bit is read only
        apb(1'h1, REG_FLAGS, 32'hd);
        m_c = 1;
        m_z = 1;
        rdchk(REG_FLAGS, 32'h5);
        // carry out of both nibbles, zero result
        push(1'h1, {OPC_ADD_IMM, 1'h0, 8'hf1});
        drain();
        final_chk();
        batch(150, 8'ha5);
        final_chk();
        batch(150, 8'h5a);
        final_chk();
        batch(150, 8'(($random(seed))));
        final_chk();
        give_verdict();
    end
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
